// ===== sensor_afe_mode_registers.sv
// Mode and test control registers of the sensor front end.
//
// Functional notes
// RL1 - 11-bit word shifted in, committed on strobe
// RL2 - Power down keeps registers, configuration needs rewrite
// RL3 - Digital reset bit restores power-up values
// RL4 - Top reference: internal when clear, external set
// RL5 - DC reference: ground when clear, pin set
// RL6 - Coupling DC/AC and polarity normal/inverted bits
// RL7 - Configuration selects single or triple channel
// RL8 - Buffer test routes buffer to observation
// RL9 - Amplifier test routes amplifier to observation
`timescale 1ns/1ps

module sensor_afe_mode_registers
    import afe_mode_pkg::*;
(
    input wire logic mclk_in,
    input wire logic rst_n_in,
    input wire logic sclk_in,
    input wire logic serial_control_data_in,
    input wire logic load_strobe_in,
    output logic [7:0] operating_mode_control_out,
    output logic [7:0] range_output_and_test_control_out,
    output afe_ctrl_t afe_ctrl_out,
    output logic soft_reset_out,
    output logic config_stale_out
);

    frame_t frame;
    logic frame_valid;
    logic [7:0] operating_mode_control;
    logic [7:0] range_output_and_test_control;
    logic config_stale;
    logic soft_reset;

    serial_frame_rx u_rx (
        .mclk_in(mclk_in),
        .rst_n_in(rst_n_in),
        .sclk_in(sclk_in),
        .serial_control_data_in(serial_control_data_in),
        .load_strobe_in(load_strobe_in),
        .frame_out(frame),
        .frame_valid_out(frame_valid)
    );

    // Write decode; a mode write with the reset bit set only resets.
    wire wr_mode = frame_valid && frame.select == SEL_OPERATING_MODE;
    wire wr_test = frame_valid && frame.select == SEL_RANGE_TEST;
    wire reset_req = wr_mode && frame.data[POS_DIGITAL_RESET]; // RL3
    wire leaving_pd = wr_mode && !frame.data[POS_POWER_DOWN]
        && operating_mode_control[POS_POWER_DOWN];

    // Register storage; rst_n_in restores every register to power-up state, a digital reset all but soft_reset.
    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            operating_mode_control <= OPERATING_MODE_RESET;
            range_output_and_test_control <= RANGE_TEST_RESET;
            config_stale <= 1'b0;
            soft_reset <= 1'b0;
        end else begin
            soft_reset <= reset_req;
            if (reset_req) begin
                operating_mode_control <= OPERATING_MODE_RESET; // RL3
                range_output_and_test_control <= RANGE_TEST_RESET; // RL3
                config_stale <= 1'b0;
            end else begin
                if (wr_mode) begin
                    operating_mode_control <= frame.data;
                end
                if (wr_test) begin
                    range_output_and_test_control <= frame.data;
                end
                // Leaving power down loses the configuration until rewritten.
                if (leaving_pd) begin
                    config_stale <= 1'b1; // RL2
                end else if (wr_mode) begin
                    config_stale <= 1'b0;
                end
            end
        end
    end

    // Decode of analog controls from the stored registers.
    wire [1:0] cfg = {operating_mode_control[POS_CONFIG_HI],
        operating_mode_control[POS_CONFIG_LO]};
    wire usable = !config_stale && !operating_mode_control[POS_POWER_DOWN];
    wire buf_t = range_output_and_test_control[POS_BUFFER_TEST];
    wire amp_t = range_output_and_test_control[POS_AMP_TEST];
    wire cnv_t = range_output_and_test_control[POS_CONV_TEST];
    // Buffer test takes priority when several observation bits are set.
    wire observe_t next_observe = buf_t ? OBSERVE_BUFFER : // RL8
        amp_t ? OBSERVE_AMPLIFIER : // RL9
        cnv_t ? OBSERVE_CONVERTER : OBSERVE_NONE;

    // Controls come from flip-flops so the analog side sees no glitches.
    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            afe_ctrl_out <= '0;
        end else begin
            afe_ctrl_out.power_down <=
                operating_mode_control[POS_POWER_DOWN]; // RL2
            afe_ctrl_out.top_reference_select <=
                operating_mode_control[POS_TOP_REF]; // RL4
            afe_ctrl_out.input_dc_reference_select <=
                operating_mode_control[POS_DC_REF]; // RL5
            afe_ctrl_out.ac_coupling <=
                operating_mode_control[POS_COUPLING]; // RL6
            afe_ctrl_out.inverted <=
                operating_mode_control[POS_POLARITY]; // RL6
            afe_ctrl_out.single_channel <=
                usable && cfg == CONFIG_SINGLE; // RL7
            afe_ctrl_out.triple_channel <=
                usable && cfg == CONFIG_TRIPLE; // RL7
            afe_ctrl_out.outputs_disabled <=
                range_output_and_test_control[POS_OUTPUT_DISABLE];
            afe_ctrl_out.offset_range_symmetric <=
                range_output_and_test_control[POS_OFFSET_RANGE];
            afe_ctrl_out.cis_reference_circuit <=
                range_output_and_test_control[POS_CIS_REF_CIRCUIT];
            afe_ctrl_out.general_test_enable <=
                range_output_and_test_control[POS_GENERAL_TEST];
            afe_ctrl_out.observe <= next_observe;
        end
    end

    assign operating_mode_control_out = operating_mode_control;
    assign range_output_and_test_control_out = range_output_and_test_control;
    assign soft_reset_out = soft_reset;
    assign config_stale_out = config_stale;

endmodule

// ===== afe_mode_pkg.sv
// Package with register map, field layout and types of the mode register bank.
package afe_mode_pkg;

    // Frame layout of one serial control word.
    localparam int FRAME_BITS = 11;
    localparam int SELECT_BITS = 3;
    localparam int DATA_BITS = 8;

    // Register select codes.
    localparam logic [2:0] SEL_OPERATING_MODE = 3'h6;
    localparam logic [2:0] SEL_RANGE_TEST = 3'h7;

    // Power-up values.
    localparam logic [7:0] OPERATING_MODE_RESET = 8'h00;
    localparam logic [7:0] RANGE_TEST_RESET = 8'h00;

    // Field positions in the operating mode control register.
    localparam int POS_POWER_DOWN = 7;
    localparam int POS_DIGITAL_RESET = 6;
    localparam int POS_TOP_REF = 5;
    localparam int POS_DC_REF = 4;
    localparam int POS_COUPLING = 3;
    localparam int POS_POLARITY = 2;
    localparam int POS_CONFIG_HI = 1;
    localparam int POS_CONFIG_LO = 0;

    // Field positions in the range, output and test control register.
    localparam int POS_UNUSED_TEST = 7;
    localparam int POS_OUTPUT_DISABLE = 6;
    localparam int POS_OFFSET_RANGE = 5;
    localparam int POS_CIS_REF_CIRCUIT = 4;
    localparam int POS_BUFFER_TEST = 3;
    localparam int POS_AMP_TEST = 2;
    localparam int POS_CONV_TEST = 1;
    localparam int POS_GENERAL_TEST = 0;

    // Signal configuration codes.
    localparam logic [1:0] CONFIG_SINGLE = 2'h1;
    localparam logic [1:0] CONFIG_TRIPLE = 2'h2;

    // Observation path selection.
    typedef enum logic [1:0] {
        OBSERVE_NONE = 2'h0,
        OBSERVE_BUFFER = 2'h1,
        OBSERVE_AMPLIFIER = 2'h3,
        OBSERVE_CONVERTER = 2'h2
    } observe_t;

    // Committed serial word.
    typedef struct packed {
        logic [2:0] select;
        logic [7:0] data;
    } frame_t;

    // Decoded analog front-end controls.
    typedef struct packed {
        logic power_down;
        logic top_reference_select;
        logic input_dc_reference_select;
        logic ac_coupling;
        logic inverted;
        logic triple_channel;
        logic single_channel;
        logic outputs_disabled;
        logic offset_range_symmetric;
        logic cis_reference_circuit;
        logic general_test_enable;
        observe_t observe;
    } afe_ctrl_t;

endpackage

// ===== serial_frame_rx.sv
// Serial shifter that assembles and commits 11-bit control words.
`timescale 1ns/1ps

module serial_frame_rx
    import afe_mode_pkg::*;
(
    input wire logic mclk_in,
    input wire logic rst_n_in,
    input wire logic sclk_in,
    input wire logic serial_control_data_in,
    input wire logic load_strobe_in,
    output frame_t frame_out,
    output logic frame_valid_out
);

    logic sclk_prev;
    logic load_prev;
    logic [10:0] shift;
    logic [3:0] count;

    // Edge detection on the serial clock and the load strobe.
    wire sclk_rise = sclk_in & ~sclk_prev;
    wire load_rise = load_strobe_in & ~load_prev;
    wire full = (count == 4'(FRAME_BITS));

    // Shift only while the strobe is low; extra clocks are ignored.
    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            sclk_prev <= 1'b0;
            load_prev <= 1'b1;
            shift <= 11'h000;
            count <= 4'h0;
        end else begin
            sclk_prev <= sclk_in;
            load_prev <= load_strobe_in;
            if (load_strobe_in) begin
                count <= 4'h0;
            end else if (sclk_rise && !full) begin
                shift <= {shift[9:0], serial_control_data_in}; // RL1
                count <= count + 4'h1;
            end
        end
    end

    // Commit on the strobe's rising edge only when a whole word arrived.
    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            frame_out <= '0;
            frame_valid_out <= 1'b0;
        end else begin
            frame_valid_out <= load_rise && full; // RL1
            if (load_rise && full) begin
                frame_out <= shift;
            end
        end
    end

endmodule

// ===== afe_mode_chk.sv
// Port checker of the mode register bank.
`timescale 1ns/1ps
module afe_mode_chk
    import afe_mode_pkg::*;
(
    input wire logic mclk_in,
    input wire logic rst_n_in,
    input wire logic load_strobe_in,
    input wire logic [7:0] operating_mode_control_out,
    input wire logic [7:0] range_output_and_test_control_out,
    input wire afe_ctrl_t afe_ctrl_out,
    input wire logic soft_reset_out,
    input wire logic config_stale_out
);
    wire [7:0] op = operating_mode_control_out;
    wire [7:0] rt = range_output_and_test_control_out;
    wire afe_ctrl_t c = afe_ctrl_out;
    // Controls trail the registers by one clock, hence the $past terms.
    default clocking @(posedge mclk_in); endclocking
    default disable iff (!rst_n_in);
    commit_a: assert property ($changed({op, rt}) |->
        $past(load_strobe_in, 2) && !$past(load_strobe_in, 3))
        else $error("register changed without commit");
    soft_reset_a: assert property (soft_reset_out |-> {op, rt} == 16'h0000)
        else $error("soft reset left a value");
    power_down_a: assert property (c.power_down == $past(op[7]))
        else $error("power down wrong");
    stale_cfg_a: assert property ($past(config_stale_out) |->
        !c.single_channel && !c.triple_channel) else $error("stale config");
    ref_sel_a: assert property ({c.top_reference_select,
        c.input_dc_reference_select} == $past(op[5:4])) else $error("ref");
    couple_pol_a: assert property ({c.ac_coupling, c.inverted} ==
        $past(op[3:2])) else $error("coupling or polarity");
    chan_cfg_a: assert property (c.triple_channel || c.single_channel |->
        $past(op[1:0]) == {c.triple_channel, c.single_channel})
        else $error("channel config");
    buffer_obs_a: assert property ($past(rt[3]) |->
        c.observe == OBSERVE_BUFFER) else $error("buffer observe");
    amp_obs_a: assert property ($past(rt[3:2]) == 2'h1 |->
        c.observe == OBSERVE_AMPLIFIER) else $error("amplifier observe");
endmodule

// ===== afe_host_model.sv
// Host model driving the serial control port.
`timescale 1ns/1ps
module afe_host_model (
    input wire logic mclk_in,
    output logic sclk_out,
    output logic serial_control_data_out,
    output logic strobe_out
);
    // Idle: strobe high and the serial clock still outside frames.
    initial begin
        sclk_out = 1'b0;
        serial_control_data_out = 1'b0;
        strobe_out = 1'b1;
    end
    // Each level holds two clocks so the edge detector cannot miss it.
    task automatic hold();
        repeat (2) @(negedge mclk_in);
    endtask
    // Shifts n clocks of w, select MSB first; surplus bits are junk.
    task automatic send(input logic [10:0] w, input int n);
        strobe_out = 1'b0;
        hold();
        for (int i = 0; i < n; i++) begin
            serial_control_data_out = (i < 11) ? w[10 - i] :
                ~serial_control_data_out;
            hold();
            sclk_out = 1'b1;
            hold();
            sclk_out = 1'b0;
        end
        hold();
        serial_control_data_out = ~serial_control_data_out;
        strobe_out = 1'b1;
        hold();
    endtask
endmodule

// ===== tb.sv
// Self-checking bench for the mode register bank.
`timescale 1ns/1ps
module tb;
    import afe_mode_pkg::*;
    logic mclk_in = 1'b0;
    logic rst_n_in = 1'b0;
    logic sclk, ser_data, strobe, srst_q, stale_q, xs;
    logic [7:0] op, rt, xo, xr, d;
    afe_ctrl_t ctrl;
    logic [17:0] notes[$];
    int mismatches = 0;
    int samples_checked = 0;
    initial forever #10 mclk_in = ~mclk_in;
    afe_host_model i_host (.mclk_in(mclk_in), .sclk_out(sclk),
        .serial_control_data_out(ser_data), .strobe_out(strobe));
    sensor_afe_mode_registers i_dut (.mclk_in(mclk_in), .rst_n_in(rst_n_in),
        .sclk_in(sclk), .serial_control_data_in(ser_data),
        .load_strobe_in(strobe), .operating_mode_control_out(op),
        .range_output_and_test_control_out(rt), .afe_ctrl_out(ctrl),
        .soft_reset_out(srst_q), .config_stale_out(stale_q));
    task automatic compare(input logic [15:0] got, exp);
        samples_checked++;
        if (got !== exp) begin
            mismatches++;
            $display("mismatch at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic tally_and_finish();
        if (mismatches == 0 && samples_checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    task automatic do_reset();
        rst_n_in = 1'b0;
        {xo, xr, xs} = '0;
        repeat (2) @(negedge mclk_in);
        rst_n_in = 1'b1;
    endtask
    // Sends a word and notes the state it must leave; short words load none.
    task automatic wr(input logic [2:0] s, input logic [7:0] v, input int n);
        logic sr;
        sr = n > 10 && s == SEL_OPERATING_MODE && v[6];
        if (n > 10 && s == SEL_RANGE_TEST) xr = v;
        if (sr) {xo, xr, xs} = '0;
        else if (n > 10 && s == SEL_OPERATING_MODE) begin
            xs = xo[7] && !v[7];
            xo = v;
        end
        notes.push_back({sr, xs, xo, xr});
        i_host.send({s, v}, n);
        repeat (5) @(negedge mclk_in);
    endtask
    // Each strobe rise is one result; it is judged once the controls settle.
    initial begin
        logic [17:0] n;
        logic sr, ok;
        logic [1:0] ob;
        forever begin
            @(posedge strobe iff rst_n_in);
            sr = 1'b0;
            repeat (4) begin
                @(negedge mclk_in);
                sr |= srst_q;
            end
            n = notes.pop_front();
            ok = !n[16] && !n[15];
            ob = n[3] ? 2'h1 : n[2] ? 2'h3 : n[1] ? 2'h2 : 2'h0;
            compare({op, rt}, n[15:0]);
            compare(16'(srst_q | sr), 16'(n[17]));
            compare(16'(stale_q), 16'(n[16]));
            compare(16'(ctrl), {3'h0, n[15], n[13:10],
                ok && n[9:8] == 2'h2, ok && n[9:8] == 2'h1, n[6:4], n[0], ob});
        end
    end
    // Mode codes, every test nibble, odd lengths, power down and resets.
    initial begin
        void'($urandom(32'h110B9F8B));
        do_reset();
        wr(SEL_OPERATING_MODE, 8'hFF, 5);
        for (int i = 0; i < 20; i++) begin
            d = $urandom;
            if (i < 4) wr(SEL_OPERATING_MODE, {2'h0, d[5:2], i[1:0]}, 11);
            else wr(SEL_RANGE_TEST, {d[7:4], i[3:0]}, 11);
        end
        wr(SEL_OPERATING_MODE, {2'h0, d[5:0]}, 14);
        wr(3'h3, 8'hFF, 11);
        wr(SEL_OPERATING_MODE, 8'h81, 11);
        wr(SEL_OPERATING_MODE, 8'h01, 11);
        wr(SEL_OPERATING_MODE, 8'h2E, 11);
        do_reset();
        wr(SEL_RANGE_TEST, 8'hAA, 10);
        wr(SEL_RANGE_TEST, 8'h5C, 11);
        wr(SEL_OPERATING_MODE, 8'h7F, 11);
        tally_and_finish();
    end
    // About 30 frames of 60 clocks fit well inside this limit.
    initial begin
        #200000;
        mismatches++;
        tally_and_finish();
    end
endmodule
bind sensor_afe_mode_registers afe_mode_chk i_chk (.mclk_in(mclk_in),
    .rst_n_in(rst_n_in), .load_strobe_in(load_strobe_in),
    .operating_mode_control_out(operating_mode_control_out),
    .range_output_and_test_control_out(range_output_and_test_control_out),
    .afe_ctrl_out(afe_ctrl_out), .soft_reset_out(soft_reset_out),
    .config_stale_out(config_stale_out));
